// [sbf_pkg.sv]
// Shared constants and types of the serial burst framing engine.
// Assumes a single core clock domain; link pins are synchronised elsewhere.
package sbf_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 10;
    localparam int SEL_W = 9;
    localparam int LEN_W = 10;
    localparam int GAP_W = 15;
    localparam int DIR_BIT = 15;
    localparam int OFS_MSB = 14;
    localparam int OFS_LSB = 5;
    localparam int CNT_MSB = 4;
    localparam int CFG_MODE_BIT = 15;
    localparam int CFG_GAP_MSB = 14;
    localparam int SEL_DMEM_BIT = 8;
    localparam int SEL_CH_MSB = 2;
    localparam logic [ADDR_W-1:0] CFG_ADDR = 10'h1a9;
    localparam logic [ADDR_W-1:0] SEL_ADDR = 10'h3ff;
    localparam logic [WORD_W-1:0] CFG_RESET = 16'h7fff;
    localparam logic [SEL_W-1:0] SEL_RESET = 9'h000;
    localparam logic [SEL_W-1:0] SEL_IFACE = 9'h100;
    localparam logic [12:0] CHECK_PATTERN = 13'h1555;
    localparam logic CKSYS_MISSING = 1'b0;
    localparam logic [LEN_W-1:0] DMEM_LEN = 10'h0c0;
    localparam logic [3:0] BIT_LAST = 4'hf;

    typedef enum logic [1:0] {
        SBF_IDLE, SBF_WRITE, SBF_READ, SBF_ERROR
    } sbf_state_e;

    typedef enum logic [2:0] {
        SBF_LS_NONE, SBF_LS_CH1, SBF_LS_CH2, SBF_LS_CH3, SBF_LS_DMEM
    } sbf_len_src_e;

    // Which length governs a long burst for a given target value
    function automatic sbf_len_src_e long_src(input logic [SEL_W-1:0] s);
        long_src = SBF_LS_NONE;
        if (s[SEL_DMEM_BIT]) begin
            if (s[SEL_CH_MSB:0] == 3'h0)
                long_src = SBF_LS_DMEM;
        end else begin
            case (s[SEL_CH_MSB:0])
                3'h1, 3'h3, 3'h5, 3'h7: long_src = SBF_LS_CH1;
                3'h2, 3'h6: long_src = SBF_LS_CH2;
                3'h4: long_src = SBF_LS_CH3;
                default: long_src = SBF_LS_NONE;
            endcase
        end
    endfunction
endpackage

// [sbf_word_if.sv]
// Word-level carrier between the serial link front end and the framing core.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
`default_nettype none
interface sbf_word_if;
    logic word_valid;
    logic [15:0] word;
    logic [15:0] tx_word;
    logic cs_active;
    logic cs_start;
    logic cs_end;
    logic part_err;
    modport link (output word_valid, word, cs_active, cs_start, cs_end,
        part_err, input tx_word);
    modport core (input word_valid, word, cs_active, cs_start, cs_end,
        part_err, output tx_word);
endinterface
`default_nettype wire

// [sbf_link.sv]
// Serial front end: synchronises the pins, assembles 16-bit words MSB first.
// Assumes clock idle low, data taken on the rising edge, changed on falling.
`timescale 1ns/1ps
`default_nettype none
module sbf_link (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Link pins
    input wire logic sclk,
    input wire logic select_line_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // Word side
    sbf_word_if.link wif
);
    typedef struct packed {
        logic [2:0] sclk_r;
        logic [2:0] cs_r;
        logic [1:0] mosi_r;
        logic [15:0] sh;
        logic [3:0] bits;
        logic [15:0] tx;
        logic miso;
        logic wv;
        logic [15:0] word;
        logic start;
        logic endp;
        logic part;
    } sbf_link_s;

    localparam sbf_link_s RST = '{cs_r: 3'h7, default: '0};
    sbf_link_s q, d;
    logic rise, fall, act, start_now;

    always_comb begin
        d = q;
        d.sclk_r = {q.sclk_r[1:0], sclk};
        d.cs_r = {q.cs_r[1:0], select_line_n};
        d.mosi_r = {q.mosi_r[0], mosi};
        d.wv = 1'b0;
        d.start = 1'b0;
        d.endp = 1'b0;
        d.part = 1'b0;
        rise = q.sclk_r[1] & ~q.sclk_r[2];
        fall = ~q.sclk_r[1] & q.sclk_r[2];
        act = ~q.cs_r[1];
        start_now = q.cs_r[2] & ~q.cs_r[1];
        if (!act) begin
            d.bits = '0;
            if (q.cs_r[1] & ~q.cs_r[2]) begin
                d.endp = 1'b1;
                d.part = (q.bits != '0);
            end
        end else if (start_now) begin
            d.start = 1'b1;
            d.bits = '0;
            d.miso = wif.tx_word[15];
            d.tx = {wif.tx_word[14:0], 1'b0};
        end else begin
            if (rise) begin
                d.sh = {q.sh[14:0], q.mosi_r[1]};
                d.bits = 4'(q.bits + 4'h1);
                if (q.bits == sbf_pkg::BIT_LAST) begin
                    d.wv = 1'b1;
                    d.word = {q.sh[14:0], q.mosi_r[1]};
                end
            end
            if (fall) begin
                // A finished word hands over to the next reply word here
                if (q.bits == '0) begin
                    d.miso = wif.tx_word[15];
                    d.tx = {wif.tx_word[14:0], 1'b0};
                end else begin
                    d.miso = q.tx[15];
                    d.tx = {q.tx[14:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst)
            q <= RST;
        else
            q <= d;
    end

    assign miso = q.miso;
    assign miso_oe = ~q.cs_r[1];
    assign wif.word_valid = q.wv;
    assign wif.word = q.word;
    assign wif.cs_active = ~q.cs_r[1];
    assign wif.cs_start = q.start;
    assign wif.cs_end = q.endp;
    assign wif.part_err = q.part;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    AST_TX_LOAD: assert property ((act && start_now) |=>
        (miso == $past(wif.tx_word[15]) && miso_oe))
        else $error("reply MSB not presented at select assertion");
endmodule // sbf_link
`default_nettype wire

// [sbf_gap_timer.sv]
// Word-gap watchdog: counts core cycles since the last word of a burst.
// Assumes kick and run come from logic on core_clk; limit zero disables it.
`timescale 1ns/1ps
`default_nettype none
module sbf_gap_timer #(
    parameter int CW = 15
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Control
    input wire logic run,
    input wire logic kick,
    input wire logic [CW-1:0] limit,
    // Result
    output logic expired
);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic exp;
    } sbf_gap_s;

    sbf_gap_s q, d;

    always_comb begin
        d = q;
        d.exp = 1'b0;
        if (!run || kick) begin
            d.cnt = '0;
        end else if (limit != '0 && q.cnt >= limit) begin
            d.exp = 1'b1;
            d.cnt = '0;
        end else begin
            d.cnt = CW'(q.cnt + 1'b1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst)
            q <= '0;
        else
            q <= d;
    end

    assign expired = q.exp;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    AST_GAP_EXPIRE: assert property ((run && !kick && limit != '0
        && q.cnt == limit) |=> expired)
        else $error("gap watchdog failed to expire at its limit");
endmodule // sbf_gap_timer
`default_nettype wire

// [sbf_engine.sv]
// Burst framing engine: decodes command words and drives the memory port.
// Assumes a one-cycle read latency on rd_data and lengths on core_clk.
`timescale 1ns/1ps
`default_nettype none
module sbf_engine #(
    parameter int LEN_W = sbf_pkg::LEN_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Serial link pins
    input wire logic sclk,
    input wire logic select_line_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // Program lengths of the three channels
    input wire logic [LEN_W-1:0] prog_len_1,
    input wire logic [LEN_W-1:0] prog_len_2,
    input wire logic [LEN_W-1:0] prog_len_3,
    // Memory and register write port
    output logic wr_en,
    output logic [sbf_pkg::ADDR_W-1:0] wr_addr,
    output logic [sbf_pkg::WORD_W-1:0] wr_data,
    output logic [sbf_pkg::SEL_W-1:0] wr_area,
    // Memory and register read port
    output logic rd_en,
    output logic [sbf_pkg::ADDR_W-1:0] rd_addr,
    output logic [sbf_pkg::SEL_W-1:0] rd_area,
    input wire logic [sbf_pkg::WORD_W-1:0] rd_data,
    // Status
    output logic frame_err,
    output logic word_err,
    output logic burst_busy,
    output logic mode_b
);
    typedef struct packed {
        sbf_pkg::sbf_state_e st;
        logic mode_b;
        logic unb;
        logic first;
        logic [sbf_pkg::ADDR_W-1:0] addr;
        logic [LEN_W-1:0] rem;
        logic [sbf_pkg::SEL_W-1:0] sel;
        logic [sbf_pkg::WORD_W-1:0] cfg;
        logic ferr;
        logic werr;
        logic wr_en;
        logic [sbf_pkg::ADDR_W-1:0] wr_addr;
        logic [sbf_pkg::WORD_W-1:0] wr_data;
        logic [sbf_pkg::SEL_W-1:0] wr_area;
        logic rd_en;
        logic rd_pend;
        logic [sbf_pkg::ADDR_W-1:0] rd_addr;
        logic [sbf_pkg::WORD_W-1:0] tx_rd;
    } sbf_core_s;

    localparam sbf_core_s RST = '{
        st: sbf_pkg::SBF_IDLE,
        sel: sbf_pkg::SEL_RESET,
        cfg: sbf_pkg::CFG_RESET,
        wr_area: sbf_pkg::SEL_RESET,
        default: '0
    };

    function automatic logic [sbf_pkg::ADDR_W-1:0] inc_addr(
        input logic [sbf_pkg::ADDR_W-1:0] a);
        inc_addr = sbf_pkg::ADDR_W'(a + 1'b1);
    endfunction

    function automatic logic [sbf_pkg::ADDR_W-1:0] cmd_ofs(
        input logic [sbf_pkg::WORD_W-1:0] w);
        cmd_ofs = w[sbf_pkg::OFS_MSB:sbf_pkg::OFS_LSB];
    endfunction

    function automatic logic [LEN_W-1:0] cmd_cnt(
        input logic [sbf_pkg::WORD_W-1:0] w);
        cmd_cnt = LEN_W'(w[sbf_pkg::CNT_MSB:0]);
    endfunction

    sbf_word_if wif ();
    sbf_core_s q, d;
    logic gap_exp;
    logic gap_run;
    logic cfg_b;
    logic last_a;
    sbf_pkg::sbf_len_src_e src;
    logic [LEN_W-1:0] long_len;

    sbf_link u_link (
        .core_clk(core_clk),
        .srst(srst),
        .sclk(sclk),
        .select_line_n(select_line_n),
        .mosi(mosi),
        .miso(miso),
        .miso_oe(miso_oe),
        .wif(wif)
    );

    // Only gap-tolerant bursts are guarded by the watchdog
    assign gap_run = (q.st == sbf_pkg::SBF_WRITE ||
        q.st == sbf_pkg::SBF_READ) && !q.mode_b;

    sbf_gap_timer #(
        .CW(sbf_pkg::GAP_W)
    ) u_gap (
        .core_clk(core_clk),
        .srst(srst),
        .run(gap_run),
        .kick(wif.word_valid),
        .limit(q.cfg[sbf_pkg::CFG_GAP_MSB:0]),
        .expired(gap_exp)
    );

    assign cfg_b = q.cfg[sbf_pkg::CFG_MODE_BIT];
    assign src = sbf_pkg::long_src(q.sel);

    always_comb begin
        case (src)
            sbf_pkg::SBF_LS_CH1: long_len = prog_len_1;
            sbf_pkg::SBF_LS_CH2: long_len = prog_len_2;
            sbf_pkg::SBF_LS_CH3: long_len = prog_len_3;
            sbf_pkg::SBF_LS_DMEM: long_len = sbf_pkg::DMEM_LEN;
            default: long_len = '0;
        endcase
    end

    // The reply word: read data during reads, else pattern plus flags
    assign wif.tx_word = (q.st == sbf_pkg::SBF_READ) ? q.tx_rd :
        {sbf_pkg::CHECK_PATTERN, sbf_pkg::CKSYS_MISSING,
        q.ferr, q.werr};

    always_comb begin
        d = q;
        d.wr_en = 1'b0;
        d.rd_en = 1'b0;
        d.rd_pend = q.rd_en;
        last_a = 1'b0;
        if (q.rd_pend) begin
            if (q.rd_addr == sbf_pkg::CFG_ADDR)
                d.tx_rd = q.cfg;
            else if (q.rd_addr == sbf_pkg::SEL_ADDR)
                d.tx_rd = sbf_pkg::WORD_W'(q.sel);
            else
                d.tx_rd = rd_data;
        end
        if (wif.cs_start)
            d.first = 1'b1;
        case (q.st)
            sbf_pkg::SBF_IDLE: begin
                // Select-framed mode only accepts the first word
                if (wif.word_valid && (!cfg_b || q.first)) begin
                    d.ferr = 1'b0;
                    d.werr = 1'b0;
                    d.mode_b = cfg_b;
                    d.unb = 1'b0;
                    d.addr = cmd_ofs(wif.word);
                    d.rem = cmd_cnt(wif.word);
                    if (cmd_cnt(wif.word) != '0 || cfg_b) begin
                        d.unb = (cmd_cnt(wif.word) == '0);
                        d.st = wif.word[sbf_pkg::DIR_BIT] ?
                            sbf_pkg::SBF_READ : sbf_pkg::SBF_WRITE;
                    end else if (cmd_ofs(wif.word) == '0) begin
                        if (long_len != '0) begin
                            d.addr = '0;
                            d.rem = long_len;
                            d.st = wif.word[sbf_pkg::DIR_BIT] ?
                                sbf_pkg::SBF_READ : sbf_pkg::SBF_WRITE;
                        end
                    end
                    // Outside select-framed mode, zero count with nonzero offset is dropped as harmless
                    if (d.st == sbf_pkg::SBF_READ) begin
                        d.rd_en = 1'b1;
                        d.rd_addr = d.addr;
                    end
                end
            end
            sbf_pkg::SBF_WRITE, sbf_pkg::SBF_READ: begin
                if (gap_exp) begin
                    d.ferr = 1'b1;
                    d.st = sbf_pkg::SBF_ERROR;
                end else if (wif.word_valid) begin
                    if (q.st == sbf_pkg::SBF_WRITE) begin
                        d.wr_en = 1'b1;
                        d.wr_addr = q.addr;
                        d.wr_data = wif.word;
                        d.wr_area = q.sel;
                        if (q.addr == sbf_pkg::CFG_ADDR)
                            d.cfg = wif.word;
                        if (q.addr == sbf_pkg::SEL_ADDR)
                            d.sel = wif.word[sbf_pkg::SEL_W-1:0];
                    end
                    d.addr = inc_addr(q.addr);
                    if (!q.mode_b) begin
                        d.rem = LEN_W'(q.rem - 1'b1);
                        last_a = (q.rem == LEN_W'(1));
                        if (last_a)
                            d.st = sbf_pkg::SBF_IDLE;
                    end else if (!q.unb) begin
                        if (q.rem != '0) begin
                            d.rem = LEN_W'(q.rem - 1'b1);
                        end else begin
                            d.ferr = 1'b1;
                            d.st = sbf_pkg::SBF_ERROR;
                        end
                    end
                    // Prefetch the next word while the read goes on
                    if (q.st == sbf_pkg::SBF_READ &&
                        d.st == sbf_pkg::SBF_READ &&
                        (q.unb || !q.mode_b || d.rem != '0)) begin
                        d.rd_en = 1'b1;
                        d.rd_addr = d.addr;
                    end
                end else if (wif.cs_end && q.mode_b) begin
                    if (!q.unb && q.rem != '0)
                        d.ferr = 1'b1;
                    d.st = sbf_pkg::SBF_IDLE;
                end
            end
            sbf_pkg::SBF_ERROR: begin
                // Surplus words are dropped until select goes away
                if (!wif.cs_active)
                    d.st = sbf_pkg::SBF_IDLE;
            end
            default: d.st = sbf_pkg::SBF_IDLE;
        endcase
        if (wif.word_valid)
            d.first = 1'b0;
        // A partial word sets its flag even in the clearing cycle
        if (wif.part_err)
            d.werr = 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (srst)
            q <= RST;
        else
            q <= d;
    end

    assign wr_en = q.wr_en;
    assign wr_addr = q.wr_addr;
    assign wr_data = q.wr_data;
    assign wr_area = q.wr_area;
    assign rd_en = q.rd_en;
    assign rd_addr = q.rd_addr;
    assign rd_area = q.sel;
    assign frame_err = q.ferr;
    assign word_err = q.werr;
    assign burst_busy = (q.st != sbf_pkg::SBF_IDLE);
    assign mode_b = q.mode_b;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_cmd_a;
        q.st == sbf_pkg::SBF_IDLE && wif.word_valid && !cfg_b;
    endsequence

    AST_CMD_WRITE: assert property ((s_cmd_a and
        (!wif.word[sbf_pkg::DIR_BIT] && cmd_cnt(wif.word) != '0)) |=>
        (q.st == sbf_pkg::SBF_WRITE && q.addr == $past(cmd_ofs(wif.word))))
        else $error("write command not decoded into offset and state");

    AST_CMD_READ: assert property ((s_cmd_a and
        (wif.word[sbf_pkg::DIR_BIT] && cmd_cnt(wif.word) != '0)) |=>
        (rd_en && rd_addr == $past(cmd_ofs(wif.word))) ##2
        (wif.tx_word == (rd_addr == sbf_pkg::CFG_ADDR ? q.cfg :
        rd_addr == sbf_pkg::SEL_ADDR ? sbf_pkg::WORD_W'(q.sel) :
        $past(rd_data))))
        else $error("read command did not fetch the first word");

    AST_LAST_WORD: assert property ((q.st == sbf_pkg::SBF_WRITE &&
        !q.mode_b && wif.word_valid && !gap_exp && q.rem == LEN_W'(1)) |=>
        (q.st == sbf_pkg::SBF_IDLE && wr_en))
        else $error("burst did not end after its last word");

    AST_GAP_ERR: assert property (gap_exp |=>
        (q.st == sbf_pkg::SBF_ERROR && frame_err))
        else $error("word gap timeout did not reach error state");

    AST_LONG_IGNORE: assert property ((s_cmd_a and
        (wif.word == '0 && src == sbf_pkg::SBF_LS_NONE)) |=>
        (q.st == sbf_pkg::SBF_IDLE) [*2])
        else $error("long burst with bad target was not ignored");

    AST_LONG_DMEM: assert property ((s_cmd_a and
        (wif.word == '0 && src == sbf_pkg::SBF_LS_DMEM)) |=>
        (q.rem == sbf_pkg::DMEM_LEN && q.addr == '0))
        else $error("data memory long burst length wrong");

    AST_EARLY_END: assert property ((q.mode_b && !q.unb &&
        q.rem != '0 && wif.cs_end && !wif.word_valid &&
        q.st == sbf_pkg::SBF_WRITE) |=>
        (frame_err && q.st == sbf_pkg::SBF_IDLE))
        else $error("short select-framed burst not flagged");

    AST_SURPLUS: assert property ((q.st == sbf_pkg::SBF_WRITE &&
        q.mode_b && !q.unb && q.rem == '0 && wif.word_valid) |=>
        (wr_en && frame_err && q.st == sbf_pkg::SBF_ERROR))
        else $error("first surplus word not stored with frame error");

    AST_DISCARD: assert property ((q.st == sbf_pkg::SBF_ERROR &&
        wif.cs_active) |=> !wr_en && !rd_en)
        else $error("word acted on while in error state");

    AST_IFACE_SEL: assert property ((q.st == sbf_pkg::SBF_WRITE &&
        wif.word_valid && !gap_exp && q.addr == sbf_pkg::SEL_ADDR &&
        wif.word[sbf_pkg::SEL_W-1:0] == sbf_pkg::SEL_IFACE) |=>
        rd_area == sbf_pkg::SEL_IFACE)
        else $error("target select write not applied");

    AST_KEEP_CTX: assert property ((q.st == sbf_pkg::SBF_WRITE &&
        !q.mode_b && wif.cs_end && !wif.word_valid && !gap_exp) |=>
        q.st == sbf_pkg::SBF_WRITE)
        else $error("gap-tolerant burst lost at select release");

    AST_WERR_SET: assert property (wif.part_err |=> word_err)
        else $error("cut word did not set the word error flag");

    AST_MODE_LATCH: assert property ((q.st == sbf_pkg::SBF_IDLE &&
        wif.word_valid && (!cfg_b || q.first)) |=> mode_b == $past(cfg_b))
        else $error("framing mode not latched with the command");

    AST_ERR_EXIT: assert property ((q.st == sbf_pkg::SBF_ERROR &&
        !wif.cs_active) |=> q.st == sbf_pkg::SBF_IDLE)
        else $error("error state not left after select release");

    AST_FREE_RUN: assert property ((q.st == sbf_pkg::SBF_WRITE &&
        q.mode_b && q.unb && wif.word_valid) |=>
        (wr_en && q.st == sbf_pkg::SBF_WRITE))
        else $error("unbounded select-framed word not written");

    CVR_LONG_CODE: cover property (s_cmd_a and (wif.word == '0 &&
        src == sbf_pkg::SBF_LS_CH1));
    CVR_MODE_B_OK: cover property (q.mode_b && q.rem == '0 &&
        wif.cs_end && !q.ferr);
    CVR_SURPLUS: cover property (q.mode_b && q.st == sbf_pkg::SBF_ERROR);
    CVR_GAP: cover property (gap_exp);
endmodule // sbf_engine
`default_nettype wire

// [sbf_host.sv]
// Host master model driving the serial link of the framing engine.
// Assumes clock idle low, data set on falling edge, MSB first.
`timescale 1ns/1ps
`default_nettype none
module sbf_host (
    // Link
    output logic sclk,
    output logic select_line_n,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        select_line_n = 1'b1;
        mosi = 1'b0;
    end
    // One word; select released after it when rel is set
    task automatic xfer(input logic [15:0] w, input bit rel,
        output logic [15:0] r);
        #3 select_line_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi = w[i];
            #100 sclk = 1'b1;
            r[i] = miso;
            #100 sclk = 1'b0;
        end
        #100;
        if (rel) begin
            select_line_n = 1'b1;
            // Released data line must not look like held data
            mosi = ~mosi;
        end
        #100;
    endtask
    // A cut word: nb bits, then select released in mid-word
    task automatic part(input int nb);
        #3 select_line_n = 1'b0;
        for (int i = 0; i < nb; i++) begin
            mosi = 1'b1;
            #100 sclk = 1'b1;
            #100 sclk = 1'b0;
        end
        #100 select_line_n = 1'b1;
        #100;
    endtask
endmodule // sbf_host
`default_nettype wire

// [tb_top.sv]
// Bench for the burst framing engine with a host model on the link.
// Assumes reads echo the address; short program lengths for long bursts.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk, srst, sclk, select_line_n, mosi, miso, miso_oe;
    logic [9:0] prog_len_1, prog_len_2, prog_len_3, wr_addr, rd_addr;
    logic [15:0] wr_data, rd_data, r;
    logic [8:0] wr_area, rd_area, sel_m;
    logic wr_en, rd_en, frame_err, word_err, burst_busy, mode_b;
    logic [34:0] wq[$];
    logic [34:0] e;
    int n_mismatch = 0, checked = 0;
    logic [9:0] ra[4] = '{10'h010, 10'h3fe, 10'h001, 10'h3ff};
    logic [15:0] rv[4] = '{16'h1234, 16'hffff, 16'h0001, 16'h0100};
    logic [8:0] ls[6] = '{9'h001, 9'h006, 9'h004, 9'h005, 9'h000, 9'h100};
    int ln[6] = '{3, 2, 4, 3, 0, 192};
    sbf_engine sbf_engine_inst (.core_clk, .srst, .sclk, .select_line_n,
        .mosi, .miso, .miso_oe, .prog_len_1, .prog_len_2, .prog_len_3,
        .wr_en, .wr_addr, .wr_data, .wr_area, .rd_en, .rd_addr, .rd_area,
        .rd_data, .frame_err, .word_err, .burst_busy, .mode_b);
    sbf_host sbf_host_inst (.sclk, .select_line_n, .mosi, .miso);
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Memory model: record writes, answer reads one cycle later
    always @(posedge core_clk) begin
        if (wr_en) wq.push_back({wr_area, wr_addr, wr_data});
        if (rd_en) rd_data <= {6'h2a, rd_addr};
    end
    task automatic chk(input string nm, input logic [34:0] s, x);
        checked++;
        if (s !== x) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wait_c(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Command then nd data words from d0 up; b releases select per word
    task automatic burst(input logic [15:0] c, d0, input int nd,
        input bit b);
        wq.delete();
        sbf_host_inst.xfer(c, b, r);
        for (int k = 0; k < nd; k++)
            sbf_host_inst.xfer(d0 + 16'(k), b || k == nd - 1, r);
        wait_c(8);
    endtask
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        burst({1'b0, a, 5'h01}, d, 1, 1'b1);
        chk("wr", wq[0], {sel_m, a, d});
        chk("nwr", wq.size(), 1);
        chk("busy", burst_busy, 0);
        if (a == 10'h3ff) sel_m = d[8:0];
    endtask
    initial begin
        srst = 1'b1;
        prog_len_1 = 10'h003;
        prog_len_2 = 10'h002;
        prog_len_3 = 10'h004;
        sel_m = 9'h000;
        wait_c(16);
        srst <= 1'b0;
        wait_c(3);
        chk("rst", {wr_en, rd_en, miso_oe, burst_busy, mode_b,
            frame_err, word_err}, 0);
        chk("rst_area", rd_area, 9'h000);
        foreach (ra[i]) begin
            wr(ra[i], rv[i]);
            chk("reply", r, 16'haaa8);
            chk("area", rd_area, sel_m);
        end
        burst({1'b1, 10'h040, 5'h01}, 16'h0000, 1, 1'b1);
        chk("rd", r, {6'h2a, 10'h040});
        burst({1'b1, 10'h3ff, 5'h01}, 16'h0000, 1, 1'b1);
        chk("rd_sel", r, {7'h00, sel_m});
        // A word takes about 140 cycles, so the limit must stay above it
        wr(10'h1a9, 16'h00c8);
        burst({1'b1, 10'h1a9, 5'h01}, 16'h0000, 1, 1'b1);
        chk("rd_cfg", r, 16'h00c8);
        sbf_host_inst.xfer({1'b0, 10'h050, 5'h01}, 1'b1, r);
        wait_c(240);
        chk("gap_err", frame_err, 1);
        chk("gap_idle", burst_busy, 0);
        foreach (ls[i]) begin
            wr(10'h3ff, {7'h00, ls[i]});
            burst(16'h0000, 16'h0000, ln[i], 1'b1);
            chk("long_n", wq.size(), ln[i]);
            e = {ls[i], 10'(ln[i] - 1), 16'(ln[i] - 1)};
            if (ln[i] > 0)
                chk("long_last", wq[$], e);
            chk("long_idle", burst_busy, 0);
        end
        wr(10'h1a9, 16'h8000);
        burst({1'b0, 10'h020, 5'h03}, 16'h00b0, 5, 1'b0);
        chk("ovr_n", wq.size(), 4);
        chk("ovr_last", wq[$], {sel_m, 10'h023, 16'h00b3});
        chk("ovr_err", frame_err, 1);
        chk("mode", mode_b, 1);
        burst({1'b0, 10'h020, 5'h03}, 16'h00c0, 1, 1'b0);
        chk("short_err", frame_err, 1);
        chk("short_n", wq.size(), 1);
        burst({1'b0, 10'h030, 5'h00}, 16'h00d0, 5, 1'b0);
        chk("free_n", wq.size(), 5);
        chk("free_last", wq[$], {sel_m, 10'h034, 16'h00d4});
        chk("free_err", frame_err, 0);
        sbf_host_inst.part(5);
        wait_c(8);
        chk("werr", word_err, 1);
        chk("werr_idle", burst_busy, 0);
        end_of_test();
    end
    initial begin
        #2000000;
        n_mismatch++;
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
